// [ufc_flow_ctrl.sv]
// Notes on behaviour
// - low nibble of feature register picks the software flow mode.
// - enhanced-enable bit zero blocks writes to INTERRUPT_ENABLE_REG 7:4, FIFO_CONTROL_REG 5:4, MODEM_CONTROL_REG 7:5.
// - special detect compares received chars with xoff2, flags ident bit 4.
// - auto RTS goes high at halt level, low again at resume level.
// - auto CTS halts transmit while CTS input is high.
// - baud generator divides by 16-bit divisor from two byte latches.
// - divisor latches writable only while sleep mode is off.
// - threshold register holds halt in 3:0, resume in 7:4, steps of four.
// - threshold writes need enhanced-enable and modem-control bit 6.
// - trigger register holds tx spaces 3:0, rx chars 7:4, value N/4.
// - trigger writes need enhanced-enable and modem-control bit 6.
// - zero trigger field falls back to the fifo control trigger.
// - ready bits 0,1 set when tx free spaces reach the trigger.
// - ready bits 4,5 set when rx count exceeds trigger or timeout.
// - fifo ready read-only at 7 via either select, bit 2 set, no loop.
// - modem bit 4 loops modem outputs and serial data internally.
`timescale 1ns/1ps
`default_nettype none

module ufc_flow_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ufc_pkg::ufc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic [6:0] rx_count_i,
  input wire logic [6:0] tx_space_i,
  input wire logic rx_timeout_i,
  input wire logic [6:0] fcr_tx_level_i,
  input wire logic [6:0] fcr_rx_level_i,
  input wire logic b_tx_ready_i,
  input wire logic b_rx_ready_i,
  input wire logic cts_i,
  input wire logic serial_in_i,
  input wire logic tx_serial_i,
  output logic rts_o,
  output logic tx_halt_o,
  output logic special_char_o,
  output logic [3:0] sw_flow_mode_o,
  output logic [6:0] tx_trigger_o,
  output logic [6:0] rx_trigger_o,
  output logic baud_tick_o,
  output logic serial_out_o,
  output logic rx_serial_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] feature_ff;
  logic [7:0] lcr_ff;
  logic [7:0] ier_ff;
  logic [7:0] fcr_ff;
  logic [7:0] mcr_ff;
  logic [7:0] div_low_ff;
  logic [7:0] div_high_ff;
  logic [7:0] thresh_ff;
  logic [7:0] trig_ff;
  logic [7:0] xoff2_ff;
  logic special_ff;
  ufc_pkg::ufc_rts_state_t rts_state_ff;
  ufc_pkg::ufc_rts_state_t nxt_rts_state;

  logic own_sel;
  logic any_sel;
  logic enh_bank;
  logic dlab;
  logic enh_en;
  logic trig_access;
  logic loopback;
  logic rdy_access;
  logic own_wr;
  logic [7:0] fifo_ready;
  logic [7:0] iir_val;
  logic [5:0] halt_level;
  logic [5:0] resume_level;
  logic cts_seen;
  logic special_hit;
  logic iir_read;

  assign own_sel = ~bus_i.sel_n[0];
  assign any_sel = ~(bus_i.sel_n[0] & bus_i.sel_n[1]);
  assign own_wr = own_sel & bus_i.wr;
  assign enh_bank = (lcr_ff == ufc_pkg::LINE_CTRL_ENH_BANK);
  assign dlab = lcr_ff[ufc_pkg::LINE_CTRL_DLAB];
  assign enh_en = feature_ff[ufc_pkg::FEAT_ENH_EN];
  assign loopback = mcr_ff[ufc_pkg::MCR_LOOPBACK];
  assign trig_access = enh_en & mcr_ff[ufc_pkg::MCR_TRIG_ACCESS];
  assign rdy_access = mcr_ff[ufc_pkg::MCR_FIFO_RDY_EN] & ~loopback;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------

  // line control is always writable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lcr_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && bus_i.addr == ufc_pkg::ADDR_LINE_CTRL) begin
      lcr_ff <= bus_i.wdata;
    end
  end

  // feature register and xoff2 live in the enhanced bank
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      feature_ff <= ufc_pkg::RESET_BYTE;
      xoff2_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && enh_bank) begin
      if (bus_i.addr == ufc_pkg::ADDR_FEATURE) begin
        feature_ff <= bus_i.wdata;
      end else if (bus_i.addr == ufc_pkg::ADDR_TRIGGER) begin
        xoff2_ff <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ier_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && !dlab && !enh_bank &&
                 bus_i.addr == ufc_pkg::ADDR_INT_ENABLE) begin
      if (enh_en) begin
        ier_ff <= bus_i.wdata;
      end else begin
        ier_ff <= (ier_ff & ufc_pkg::IER_ENH_MASK) |
                  (bus_i.wdata & ~ufc_pkg::IER_ENH_MASK);
      end
    end
  end

  // masked fifo control bits
  // fifo control is write-only at the feature offset outside the bank
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fcr_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && !enh_bank &&
                 bus_i.addr == ufc_pkg::ADDR_FEATURE) begin
      if (enh_en) begin
        fcr_ff <= bus_i.wdata;
      end else begin
        fcr_ff <= (fcr_ff & ufc_pkg::FCR_ENH_MASK) |
                  (bus_i.wdata & ~ufc_pkg::FCR_ENH_MASK);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mcr_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && !enh_bank &&
                 bus_i.addr == ufc_pkg::ADDR_MODEM_CTRL) begin
      if (enh_en) begin
        mcr_ff <= bus_i.wdata;
      end else begin
        mcr_ff <= (mcr_ff & ufc_pkg::MCR_ENH_MASK) |
                  (bus_i.wdata & ~ufc_pkg::MCR_ENH_MASK);
      end
    end
  end

  // two byte latches
  // loading the divisor in sleep would glitch a stopped oscillator
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_low_ff <= ufc_pkg::RESET_BYTE;
      div_high_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && dlab && !enh_bank &&
                 !ier_ff[ufc_pkg::IER_SLEEP]) begin
      if (bus_i.addr == ufc_pkg::ADDR_DIV_LOW) begin
        div_low_ff <= bus_i.wdata;
      end else if (bus_i.addr == ufc_pkg::ADDR_DIV_HIGH) begin
        div_high_ff <= bus_i.wdata;
      end
    end
  end

  // no order check on halt and resume
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thresh_ff <= ufc_pkg::RESET_BYTE;
      trig_ff <= ufc_pkg::RESET_BYTE;
    end else if (own_wr && !enh_bank && trig_access) begin
      if (bus_i.addr == ufc_pkg::ADDR_THRESH) begin
        thresh_ff <= bus_i.wdata;
      end else if (bus_i.addr == ufc_pkg::ADDR_TRIGGER) begin
        trig_ff <= bus_i.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // special character detect
  // ----------------------------------------------------------------
  // compare with xoff2
  assign special_hit = rx_valid_i & feature_ff[ufc_pkg::FEAT_SPECIAL] &
                       (rx_char_i == xoff2_ff);
  assign iir_read = own_sel & bus_i.rd & !enh_bank &
                    (bus_i.addr == ufc_pkg::ADDR_FEATURE);

  // reading the ident register clears the flag; a new match wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      special_ff <= 1'b0;
    end else if (special_hit) begin
      special_ff <= 1'b1;
    end else if (iir_read) begin
      special_ff <= 1'b0;
    end
  end

  always_comb begin
    iir_val = ufc_pkg::RESET_BYTE;
    iir_val[ufc_pkg::IIR_NO_INT] = ~special_ff;
    iir_val[ufc_pkg::IIR_SPECIAL] = special_ff;
    iir_val[7:6] = {2{fcr_ff[ufc_pkg::FCR_FIFO_EN]}};
  end

  // ----------------------------------------------------------------
  // trigger selection and fifo ready
  // ----------------------------------------------------------------
  // zero field uses fifo control level
  // stored value is level over four
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_trigger_o <= 7'h00;
      rx_trigger_o <= 7'h00;
    end else begin
      tx_trigger_o <= (trig_ff[3:0] == ufc_pkg::TRIG_FROM_FCR) ?
                      fcr_tx_level_i : {1'b0, trig_ff[3:0], 2'b00};
      rx_trigger_o <= (trig_ff[7:4] == ufc_pkg::TRIG_FROM_FCR) ?
                      fcr_rx_level_i : {1'b0, trig_ff[7:4], 2'b00};
    end
  end

  always_comb begin
    fifo_ready = ufc_pkg::RESET_BYTE;
    fifo_ready[ufc_pkg::RDY_TX_A] = (tx_space_i >= tx_trigger_o);
    fifo_ready[ufc_pkg::RDY_TX_B] = b_tx_ready_i;
    fifo_ready[ufc_pkg::RDY_RX_A] = (rx_count_i > rx_trigger_o) |
                                    rx_timeout_i;
    fifo_ready[ufc_pkg::RDY_RX_B] = b_rx_ready_i;
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // ready register via either select
  // data is held until the next read; unmapped reads answer zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= ufc_pkg::RESET_BYTE;
    end else if (bus_i.rd && any_sel) begin
      if (!own_sel) begin
        rdata_o <= (bus_i.addr == ufc_pkg::ADDR_TRIGGER && rdy_access) ?
                   fifo_ready : ufc_pkg::RESET_BYTE;
      end else if (bus_i.addr == ufc_pkg::ADDR_LINE_CTRL) begin
        rdata_o <= lcr_ff;
      end else if (enh_bank && bus_i.addr == ufc_pkg::ADDR_FEATURE) begin
        rdata_o <= feature_ff;
      end else if (enh_bank && bus_i.addr == ufc_pkg::ADDR_TRIGGER) begin
        rdata_o <= xoff2_ff;
      end else if (enh_bank) begin
        rdata_o <= ufc_pkg::RESET_BYTE;
      end else if (dlab && bus_i.addr == ufc_pkg::ADDR_DIV_LOW) begin
        rdata_o <= div_low_ff;
      end else if (dlab && bus_i.addr == ufc_pkg::ADDR_DIV_HIGH) begin
        rdata_o <= div_high_ff;
      end else if (bus_i.addr == ufc_pkg::ADDR_INT_ENABLE) begin
        rdata_o <= ier_ff;
      end else if (bus_i.addr == ufc_pkg::ADDR_FEATURE) begin
        rdata_o <= iir_val;
      end else if (bus_i.addr == ufc_pkg::ADDR_MODEM_CTRL) begin
        rdata_o <= mcr_ff;
      end else if (bus_i.addr == ufc_pkg::ADDR_THRESH && trig_access) begin
        rdata_o <= thresh_ff;
      end else if (bus_i.addr == ufc_pkg::ADDR_TRIGGER && trig_access) begin
        rdata_o <= trig_ff;
      end else if (bus_i.addr == ufc_pkg::ADDR_TRIGGER && rdy_access) begin
        rdata_o <= fifo_ready;
      end else begin
        rdata_o <= ufc_pkg::RESET_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // auto RTS hysteresis
  // ----------------------------------------------------------------
  // levels in steps of four
  assign halt_level = {thresh_ff[3:0], 2'b00};
  assign resume_level = {thresh_ff[7:4], 2'b00};

  // halt and resume thresholds
  // with halt not above resume the state may toggle every cycle
  always_comb begin
    nxt_rts_state = rts_state_ff;
    case (rts_state_ff)
      ufc_pkg::UFC_RTS_RUN: begin
        if (rx_count_i >= {1'b0, halt_level}) begin
          nxt_rts_state = ufc_pkg::UFC_RTS_HALT;
        end
      end
      ufc_pkg::UFC_RTS_HALT: begin
        if (rx_count_i <= {1'b0, resume_level}) begin
          nxt_rts_state = ufc_pkg::UFC_RTS_RUN;
        end
      end
      default: begin
        nxt_rts_state = ufc_pkg::UFC_RTS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rts_state_ff <= ufc_pkg::UFC_RTS_RUN;
    end else if (!feature_ff[ufc_pkg::FEAT_AUTO_RTS]) begin
      rts_state_ff <= ufc_pkg::UFC_RTS_RUN;
    end else begin
      rts_state_ff <= nxt_rts_state;
    end
  end

  // ----------------------------------------------------------------
  // pins, CTS gating and loopback
  // ----------------------------------------------------------------
  // modem RTS bit stands in for CTS
  assign cts_seen = loopback ? ~mcr_ff[ufc_pkg::MCR_RTS] : cts_i;

  // pins idle inactive (high) in loopback so the line stays quiet
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rts_o <= 1'b1;
      tx_halt_o <= 1'b0;
      serial_out_o <= 1'b1;
      rx_serial_o <= 1'b1;
    end else begin
      if (loopback) begin
        rts_o <= 1'b1;
      end else if (feature_ff[ufc_pkg::FEAT_AUTO_RTS]) begin
        rts_o <= (rts_state_ff == ufc_pkg::UFC_RTS_HALT);
      end else begin
        rts_o <= ~mcr_ff[ufc_pkg::MCR_RTS];
      end
      tx_halt_o <= feature_ff[ufc_pkg::FEAT_AUTO_CTS] & cts_seen;
      serial_out_o <= loopback ? 1'b1 : tx_serial_i;
      rx_serial_o <= loopback ? tx_serial_i : serial_in_i;
    end
  end

  assign sw_flow_mode_o = feature_ff[3:0];
  assign special_char_o = special_ff;

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  logic [1:0] pre_cnt_ff;
  logic [15:0] div_cnt_ff;
  logic pre_tick;
  logic [15:0] divisor;

  assign divisor = {div_high_ff, div_low_ff};
  assign pre_tick = ~mcr_ff[ufc_pkg::MCR_PRESCALE4] |
                    (pre_cnt_ff == ufc_pkg::PRESCALE_LAST);

  // optional divide by four ahead of the divisor
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_cnt_ff <= 2'h0;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 2'h1;
    end
  end

  // divide by 16-bit divisor
  // a zero divisor stops the tick rather than running flat out
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt_ff <= ufc_pkg::RESET_DIVISOR;
      baud_tick_o <= 1'b0;
    end else if (divisor == ufc_pkg::RESET_DIVISOR) begin
      div_cnt_ff <= ufc_pkg::RESET_DIVISOR;
      baud_tick_o <= 1'b0;
    end else if (pre_tick) begin
      if (div_cnt_ff <= 16'h0001) begin
        div_cnt_ff <= divisor;
        baud_tick_o <= 1'b1;
      end else begin
        div_cnt_ff <= div_cnt_ff - 16'h0001;
        baud_tick_o <= 1'b0;
      end
    end else begin
      baud_tick_o <= 1'b0;
    end
  end

endmodule : ufc_flow_ctrl

`default_nettype wire

// [ufc_pkg.sv]
package ufc_pkg;

  // ----------------------------------------------------------------
  // register offsets (address pins)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1; // also interrupt enable
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_FEATURE = 3'h2; // also fifo control / ident
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_THRESH = 3'h6;
  localparam logic [2:0] ADDR_TRIGGER = 3'h7; // also xoff2 / fifo ready

  // line control value that opens the enhanced bank
  localparam logic [7:0] LINE_CTRL_ENH_BANK = 8'hbf;
  localparam int LINE_CTRL_DLAB = 7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FEAT_ENH_EN = 4;
  localparam int FEAT_SPECIAL = 5;
  localparam int FEAT_AUTO_RTS = 6;
  localparam int FEAT_AUTO_CTS = 7;
  localparam int IER_SLEEP = 4;
  localparam int MCR_RTS = 1;
  localparam int MCR_FIFO_RDY_EN = 2;
  localparam int MCR_LOOPBACK = 4;
  localparam int MCR_TRIG_ACCESS = 6;
  localparam int MCR_PRESCALE4 = 7;
  localparam int FCR_FIFO_EN = 0;
  localparam int IIR_NO_INT = 0;
  localparam int IIR_SPECIAL = 4;

  // write masks for bits that only the enhanced-enable bit unlocks
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;

  // fifo ready layout, unused bits read zero
  localparam int RDY_TX_A = 0;
  localparam int RDY_TX_B = 1;
  localparam int RDY_RX_A = 4;
  localparam int RDY_RX_B = 5;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;

  // prescaler last count for divide by four
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] TRIG_FROM_FCR = 4'h0;

  // ----------------------------------------------------------------
  // bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sel_n; // channel chip selects, A in bit 0
    logic [2:0] addr;
    logic wr; // one-cycle write strobe
    logic rd; // one-cycle read strobe
    logic [7:0] wdata;
  } ufc_bus_req_t;

  typedef enum logic [1:0] {
    UFC_RTS_RUN = 2'b00,
    UFC_RTS_HALT = 2'b01
  } ufc_rts_state_t;

endpackage : ufc_pkg

// [ufc_flow_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

module ufc_flow_ctrl_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ufc_pkg::ufc_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic [6:0] rx_count_i,
  input wire logic [6:0] tx_space_i,
  input wire logic rx_timeout_i,
  input wire logic b_tx_ready_i,
  input wire logic b_rx_ready_i,
  input wire logic cts_i,
  input wire logic serial_in_i,
  input wire logic tx_serial_i,
  input wire logic rts_o,
  input wire logic tx_halt_o,
  input wire logic special_char_o,
  input wire logic [3:0] sw_flow_mode_o,
  input wire logic [6:0] tx_trigger_o,
  input wire logic [6:0] rx_trigger_o,
  input wire logic serial_out_o,
  input wire logic rx_serial_o
);
  logic [7:0] line_ctrl_ff, feat_ff, modem_ff, xoff2_ff;
  logic wr_a, normal, iir_rd, rdy_rd, tx_a, rx_a;

  // ----------------------------------------------------------------
  // shadow of the bank registers, seen from the bus alone
  // ----------------------------------------------------------------
  assign wr_a = bus_i.wr && !bus_i.sel_n[0];
  assign normal = line_ctrl_ff != 8'hbf;
  assign iir_rd = bus_i.rd && !bus_i.sel_n[0] && bus_i.addr == 3'h2 && normal;
  assign rdy_rd = bus_i.rd && bus_i.addr == 3'h7 && normal && modem_ff[2] &&
                  !modem_ff[4];
  assign tx_a = tx_space_i >= tx_trigger_o;
  assign rx_a = rx_count_i > rx_trigger_o || rx_timeout_i;

  // shadow writes follow the same bank decode as the block
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_ctrl_ff <= 8'h00;
      feat_ff <= 8'h00;
      modem_ff <= 8'h00;
      xoff2_ff <= 8'h00;
    end else if (wr_a) begin
      if (bus_i.addr == 3'h3) line_ctrl_ff <= bus_i.wdata;
      if (!normal && bus_i.addr == 3'h2) feat_ff <= bus_i.wdata;
      if (!normal && bus_i.addr == 3'h7) xoff2_ff <= bus_i.wdata;
      if (normal && bus_i.addr == 3'h4) begin
        modem_ff <= feat_ff[4] ? bus_i.wdata :
                    {modem_ff[7:5], bus_i.wdata[4:0]};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // receive fifo above every possible halt level
  sequence s_full;
    feat_ff[6] && !modem_ff[4] && rx_count_i > 7'd60;
  endsequence

  a_mode_write: assert property (
    wr_a && !normal && bus_i.addr == 3'h2 |=> sw_flow_mode_o == feat_ff[3:0])
    else $error("flow mode differs from written value");
  a_rts_halt: assert property (s_full ##1 s_full |=> rts_o)
    else $error("rts low with full receive fifo");
  a_cts_halt: assert property (
    feat_ff[7] && cts_i && !modem_ff[4] |=> tx_halt_o)
    else $error("transmit not halted by cts");
  a_cts_off: assert property (!feat_ff[7] |=> !tx_halt_o)
    else $error("transmit halted without auto cts");
  a_special_set: assert property (
    feat_ff[5] && rx_valid_i && rx_char_i == xoff2_ff |=> special_char_o)
    else $error("special char not flagged");
  a_special_hold: assert property (
    special_char_o && !iir_rd |=> special_char_o)
    else $error("special flag lost without read");
  a_iir_flag: assert property (
    iir_rd && !line_ctrl_ff[7] |=>
    rdata_o[4] == $past(special_char_o) && rdata_o[0] != $past(special_char_o))
    else $error("ident bits disagree with special flag");
  a_ready_own: assert property (
    rdy_rd && !bus_i.sel_n[0] && !(feat_ff[4] && modem_ff[6]) |=>
    rdata_o[0] == $past(tx_a) && rdata_o[4] == $past(rx_a) &&
    rdata_o[7:6] == 2'b00 && rdata_o[3:2] == 2'b00)
    else $error("ready status wrong on own select");
  a_ready_other: assert property (
    rdy_rd && bus_i.sel_n == 2'b01 |=>
    rdata_o[1] == $past(b_tx_ready_i) && rdata_o[5] == $past(b_rx_ready_i))
    else $error("ready status wrong on other select");
  a_loop_serial: assert property (
    modem_ff[4] |=> serial_out_o && rx_serial_o == $past(tx_serial_i))
    else $error("loopback serial path wrong");
  a_rx_serial: assert property (
    !modem_ff[4] |=> rx_serial_o == $past(serial_in_i))
    else $error("receive serial path wrong");

  c_rts_halt: cover property (rts_o && feat_ff[6]);
  c_special: cover property (special_char_o);
  c_halt: cover property (tx_halt_o);
endmodule : ufc_flow_ctrl_asserts

bind ufc_flow_ctrl ufc_flow_ctrl_asserts ufc_flow_ctrl_asserts_i (
  .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i), .rx_count_i(rx_count_i),
  .tx_space_i(tx_space_i), .rx_timeout_i(rx_timeout_i),
  .b_tx_ready_i(b_tx_ready_i), .b_rx_ready_i(b_rx_ready_i), .cts_i(cts_i),
  .serial_in_i(serial_in_i), .tx_serial_i(tx_serial_i), .rts_o(rts_o),
  .tx_halt_o(tx_halt_o), .special_char_o(special_char_o),
  .sw_flow_mode_o(sw_flow_mode_o), .tx_trigger_o(tx_trigger_o),
  .rx_trigger_o(rx_trigger_o), .serial_out_o(serial_out_o),
  .rx_serial_o(rx_serial_o));
`default_nettype wire

// [ufc_peer_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ufc_peer_model (
  input wire logic clk_i,
  input wire logic pause_i,
  output logic cts_o,
  output logic line_o
);
  // line toggles every cycle so a stale serial path never matches
  initial begin
    cts_o = 1'b0;
    line_o = 1'b1;
  end

  always @(negedge clk_i) begin
    cts_o <= pause_i;
    line_o <= ~line_o;
  end
endmodule : ufc_peer_model
`default_nettype wire

// [ufc_flow_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
  end \
end

module ufc_flow_ctrl_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ufc_pkg::ufc_bus_req_t bus = '{2'b11, 3'h0, 1'b0, 1'b0, 8'h00};
  logic rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic [6:0] rx_count = 7'h00;
  logic [6:0] tx_space = 7'h00;
  logic rx_to = 1'b0;
  logic [6:0] fcr_tx = 7'h08;
  logic [6:0] fcr_rx = 7'h10;
  logic b_tx = 1'b0;
  logic b_rx = 1'b0;
  logic pause = 1'b0;
  logic tx_ser = 1'b0;
  logic [7:0] d;
  wire logic [7:0] rdata;
  wire logic cts, ser_in, rts, halt, spec, tick, sout, rxser;
  wire logic [3:0] mode;
  wire logic [6:0] ttrig, rtrig;
  int bad_count = 0;
  int samples_checked = 0;

  ufc_flow_ctrl ufc_flow_ctrl_i (.clk_i(clk), .reset_i(rst), .bus_i(bus),
    .rdata_o(rdata), .rx_valid_i(rx_valid), .rx_char_i(rx_char),
    .rx_count_i(rx_count), .tx_space_i(tx_space), .rx_timeout_i(rx_to),
    .fcr_tx_level_i(fcr_tx), .fcr_rx_level_i(fcr_rx), .b_tx_ready_i(b_tx),
    .b_rx_ready_i(b_rx), .cts_i(cts), .serial_in_i(ser_in),
    .tx_serial_i(tx_ser), .rts_o(rts), .tx_halt_o(halt),
    .special_char_o(spec), .sw_flow_mode_o(mode), .tx_trigger_o(ttrig),
    .rx_trigger_o(rtrig), .baud_tick_o(tick), .serial_out_o(sout),
    .rx_serial_o(rxser));

  ufc_peer_model ufc_peer_model_i (.clk_i(clk), .pause_i(pause),
    .cts_o(cts), .line_o(ser_in));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus cycles, driven on the falling edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    bus.sel_n = 2'b10;
    bus.addr = a;
    bus.wdata = v;
    bus.wr = 1'b1;
    @(negedge clk);
    bus.wr = 1'b0;
    bus.sel_n = 2'b11;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [1:0] s);
    @(negedge clk);
    bus.sel_n = s;
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge clk);
    bus.rd = 1'b0;
    bus.sel_n = 2'b11;
    d = rdata;
  endtask : rd

  // feature register lives only in the enhanced bank
  task automatic feat(input logic [7:0] v);
    wr(3'h3, 8'hbf);
    wr(3'h2, v);
    wr(3'h3, 8'h00);
  endtask : feat

  task automatic results;
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_gate;
    wr(3'h4, 8'hff);
    rd(3'h4, 2'b10);
    `CHK(d, 8'h1f)
    feat(8'h1a);
    `CHK(mode, 4'ha)
    wr(3'h4, 8'hff);
    rd(3'h4, 2'b10);
    `CHK(d, 8'hff)
    wr(3'h4, 8'h40);
  endtask : t_gate

  // gated writes made with modem bit 6 cleared are dropped; the earlier values read back
  task automatic t_thresh;
    wr(3'h6, 8'h24);
    wr(3'h7, 8'h31);
    wr(3'h4, 8'h00);
    wr(3'h6, 8'h55);
    wr(3'h7, 8'h55);
    wr(3'h4, 8'h40);
    rd(3'h6, 2'b10);
    `CHK(d, 8'h24)
    rd(3'h7, 2'b10);
    `CHK(d, 8'h31)
    `CHK(ttrig, 7'd4)
    `CHK(rtrig, 7'd12)
    wr(3'h7, 8'h30);
    @(negedge clk);
    `CHK(ttrig, fcr_tx)
    `CHK(rtrig, 7'd12)
    wr(3'h7, 8'h03);
    @(negedge clk);
    `CHK(rtrig, fcr_rx)
    `CHK(ttrig, 7'd12)
  endtask : t_thresh

  // tx trigger is 12, rx trigger falls back to 16
  task automatic t_ready;
    wr(3'h4, 8'h04);
    for (int i = 0; i < 4; i++) begin
      tx_space = 7'd11 + 7'(i[0]);
      rx_count = 7'd16 + 7'(i[1]);
      b_tx = i[1];
      b_rx = i[0];
      rd(3'h7, 2'b10);
      `CHK(d, {2'b00, b_rx, i[1], 2'b00, b_tx, i[0]})
      rd(3'h7, 2'b01);
      `CHK(d, {2'b00, b_rx, i[1], 2'b00, b_tx, i[0]})
    end
    rx_count = 7'd0;
    rx_to = 1'b1;
    rd(3'h7, 2'b10);
    `CHK(d, 8'h33)
    wr(3'h4, 8'h14);
    tx_ser = 1'b1;
    rd(3'h7, 2'b10);
    `CHK(d, 8'h00)
    `CHK({sout, rxser}, 2'b11)
    tx_ser = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(rxser, 1'b0)
    rx_to = 1'b0;
    wr(3'h4, 8'h40);
  endtask : t_ready

  // halt at 16, resume at 8; the host set halt above resume first
  task automatic t_rts;
    logic [6:0] cnt [6] = '{7'd15, 7'd16, 7'd9, 7'd8, 7'd64, 7'd0};
    logic [5:0] exp = 6'b010110;
    feat(8'h50);
    for (int i = 0; i < 6; i++) begin
      rx_count = cnt[i];
      repeat (3) @(negedge clk);
      `CHK(rts, exp[i])
    end
  endtask : t_rts

  task automatic t_cts;
    feat(8'h90);
    pause = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(halt, 1'b1)
    pause = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(halt, 1'b0)
    pause = 1'b1;
    feat(8'h10);
    `CHK(halt, 1'b0)
    pause = 1'b0;
  endtask : t_cts

  task automatic t_special;
    wr(3'h3, 8'hbf);
    wr(3'h7, 8'h13);
    wr(3'h2, 8'h30);
    wr(3'h3, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      rx_char = 8'h14 - 8'(i);
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
      `CHK(spec, i[0])
    end
    rd(3'h2, 2'b10);
    `CHK({d[4], d[0]}, 2'b10)
    `CHK(spec, 1'b0)
  endtask : t_special

  // waits out any old count before counting ticks in whole periods
  task automatic ticks(input int n, input int e);
    logic [9:0] k;
    k = 0;
    repeat (260) @(negedge clk);
    repeat (n) begin
      @(negedge clk);
      k += 10'(tick);
    end
    `CHK(k, e)
  endtask : ticks

  task automatic t_div;
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    ticks(512, 2);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h02);
    ticks(20, 10);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h10);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h05);
    ticks(20, 10);
    wr(3'h3, 8'h00);
    // divide by four ahead of the divisor
    wr(3'h4, 8'hc0);
    ticks(40, 5);
    wr(3'h4, 8'h40);
  endtask : t_div

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_gate();
    t_thresh();
    t_ready();
    t_rts();
    t_cts();
    t_special();
    t_div();
    results();
  end

  // watchdog, well beyond the few thousand cycles the run needs
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : ufc_flow_ctrl_test
`default_nettype wire
